// file: serial_adc_pkg.sv
// ==========================================================================
// Shared constants and types
package serial_adc_pkg;

    // Widths, channel count and buffer depth of the result path
    localparam int RESULT_BITS = 8;
    localparam int SHIFT_BITS = 9;
    localparam int CHANNELS = 8;
    localparam int FIFO_DEPTH = 16;

    // Assignment word length after the start bit, per variant
    localparam logic [2:0] ADDR_BITS_FOUR = 3'h3;
    localparam logic [2:0] ADDR_BITS_EIGHT = 3'h4;

    // Approximation sequence
    localparam logic [2:0] MSB_INDEX = 3'h7;
    localparam logic [7:0] TRIAL_FIRST = 8'h80;
    localparam logic [7:0] TRIAL_ONE = 8'h01;

    // Reset values
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [8:0] SHIFT_RESET = 9'h000;
    localparam logic [7:0] SEL_RESET = 8'h00;

    // Control sequence of one selection
    typedef enum logic [2:0] {
        ST_START = 3'h0,
        ST_ADDR = 3'h1,
        ST_HOLD = 3'h2,
        ST_CONV = 3'h3,
        ST_LSB = 3'h4
    } conv_state_t;

endpackage

// file: result_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Result FIFO with valid/ready on both sides
module result_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
        logic not_full;
        logic not_empty;
    } fifo_t;

    fifo_t st;
    fifo_t next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign push = in_valid && st.not_full;
    assign pop = out_ready && st.not_empty;
    assign in_ready = st.not_full;
    assign out_valid = st.not_empty;
    assign out_data = mem[st.rd_ptr];

    // Pointer and flag update
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wr_ptr = st.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_st.rd_ptr = st.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_st.count = st.count + 1'b1;
        end else if (pop && !push) begin
            next_st.count = st.count - 1'b1;
        end
        next_st.not_full = (next_st.count != (AW + 1)'(DEPTH));
        next_st.not_empty = (next_st.count != '0);
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '{wr_ptr: '0, rd_ptr: '0, count: '0, not_full: 1'b1, not_empty: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // Storage, written only on an accepted push
    always_ff @(posedge clk) begin
        if (push) begin
            mem[st.wr_ptr] <= in_data;
        end
    end

endmodule
`default_nettype wire

// file: channel_decode.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Assignment word to analog switch enables
module channel_decode (
    input wire logic eight_channel_mode,
    input wire logic single_or_pair_bit,
    input wire logic odd_bit,
    input wire logic [1:0] select_bits,
    output logic [serial_adc_pkg::CHANNELS-1:0] pos_sel,
    output logic [serial_adc_pkg::CHANNELS-1:0] neg_sel,
    output logic neg_common
);
    import serial_adc_pkg::*;

    logic [2:0] pos_idx;
    logic [2:0] neg_idx;

    // Channel index: twice the select value (upper select bit only in four-channel mode) plus the polarity bit
    assign pos_idx = eight_channel_mode ? {select_bits, odd_bit}
                                        : {1'b0, select_bits[1], odd_bit};
    assign neg_idx = {pos_idx[2:1], ~pos_idx[0]};
    assign neg_common = single_or_pair_bit && eight_channel_mode;

    // One switch pair per channel
    for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
        assign pos_sel[i] = (pos_idx == 3'(i));
        assign neg_sel[i] = !single_or_pair_bit && (neg_idx == 3'(i));
    end

endmodule
`default_nettype wire

// file: serial_mux_adc_control.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Serial multiplexed converter control
module serial_mux_adc_control (
    input wire logic clk,
    input wire logic rst,
    input wire logic eight_channel_mode,
    input wire logic select_line_n,
    input wire logic conv_clock,
    input wire logic serial_in_line,
    input wire logic lsb_first_strobe_n,
    output logic serial_out_line,
    output logic serial_out_en_n,
    output logic conversion_busy_flag,
    input wire logic compare_high,
    input wire logic pos_below_neg,
    output logic [serial_adc_pkg::RESULT_BITS-1:0] trial_code,
    output logic [serial_adc_pkg::CHANNELS-1:0] pos_channel_sel,
    output logic [serial_adc_pkg::CHANNELS-1:0] neg_channel_sel,
    output logic shared_negative_input,
    output logic result_valid,
    output logic [serial_adc_pkg::RESULT_BITS-1:0] result_data,
    input wire logic result_ready
);
    import serial_adc_pkg::*;

    // ======================================================================
    // State
    typedef struct packed {
        conv_state_t state;
        logic clk_prev;
        logic [2:0] shift_in;
        logic [2:0] bit_cnt;
        logic single_or_pair_bit;
        logic odd_bit;
        logic [1:0] select_bits;
        logic [7:0] approximation_register;
        logic [7:0] trial;
        logic [8:0] out_shift;
        logic data_out;
        logic data_out_en_n;
        logic busy;
        logic [7:0] pos_sel;
        logic [7:0] neg_sel;
        logic neg_common;
        logic push;
    } ctl_t;

    ctl_t st;
    ctl_t next_st;
    logic conv_edge;
    logic resolved_bit;
    logic [2:0] addr_need;
    logic addr_last;
    logic fifo_in_ready;
    logic [7:0] dec_pos;
    logic [7:0] dec_neg;
    logic dec_common;

    // ======================================================================
    // Submodules
    channel_decode u_decode (
        .eight_channel_mode(eight_channel_mode),
        .single_or_pair_bit(st.single_or_pair_bit),
        .odd_bit(st.odd_bit),
        .select_bits(st.select_bits),
        .pos_sel(dec_pos),
        .neg_sel(dec_neg),
        .neg_common(dec_common)
    );

    result_fifo #(
        .WIDTH(RESULT_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(st.push),
        .in_data(st.approximation_register),
        .in_ready(fifo_in_ready),
        .out_valid(result_valid),
        .out_data(result_data),
        .out_ready(result_ready)
    );

    // ======================================================================
    // Edge detect and helpers
    assign conv_edge = conv_clock && !st.clk_prev;
    assign resolved_bit = compare_high && !pos_below_neg;
    assign addr_need = eight_channel_mode ? ADDR_BITS_EIGHT : ADDR_BITS_FOUR;
    assign addr_last = (st.bit_cnt == addr_need - 3'h1);

    // Next state of the sequencer
    always_comb begin
        next_st = st;
        next_st.clk_prev = conv_clock;
        next_st.push = 1'b0;
        if (select_line_n) begin
            // Deselect clears everything, output released
            next_st = '0;
            next_st.state = ST_START;
            next_st.clk_prev = conv_clock;
            next_st.data_out_en_n = 1'b1;
        end else if (conv_edge) begin
            unique case (st.state)
                ST_START: begin
                    if (serial_in_line) begin
                        next_st.state = ST_ADDR;
                        next_st.bit_cnt = 3'h0;
                    end
                end
                ST_ADDR: begin
                    next_st.shift_in = {st.shift_in[1:0], serial_in_line};
                    next_st.bit_cnt = st.bit_cnt + 3'h1;
                    if (addr_last) begin
                        if (eight_channel_mode) begin
                            next_st.single_or_pair_bit = st.shift_in[2];
                            next_st.odd_bit = st.shift_in[1];
                            next_st.select_bits = {st.shift_in[0], serial_in_line};
                        end else begin
                            next_st.single_or_pair_bit = st.shift_in[1];
                            next_st.odd_bit = st.shift_in[0];
                            next_st.select_bits = {serial_in_line, 1'b1};
                        end
                        next_st.state = ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    // Start only with room for the result; input ignored here
                    if (fifo_in_ready) begin
                        next_st.state = ST_CONV;
                        next_st.busy = 1'b1;
                        next_st.data_out_en_n = 1'b0;
                        next_st.data_out = 1'b0;
                        next_st.trial = TRIAL_FIRST;
                        next_st.approximation_register = RESULT_RESET;
                        next_st.bit_cnt = MSB_INDEX;
                    end
                end
                ST_CONV: begin
                    // Resolve one bit per edge, shown at once
                    next_st.approximation_register[st.bit_cnt] = resolved_bit;
                    next_st.data_out = resolved_bit;
                    if (st.bit_cnt == 3'h0) begin
                        next_st.busy = 1'b0;
                        next_st.push = 1'b1;
                        next_st.trial = RESULT_RESET;
                        next_st.out_shift = {1'b0, next_st.approximation_register};
                        next_st.state = ST_LSB;
                    end else begin
                        next_st.bit_cnt = st.bit_cnt - 3'h1;
                        next_st.trial = next_st.approximation_register
                                        | (TRIAL_ONE << (st.bit_cnt - 3'h1));
                    end
                end
                ST_LSB: begin
                    // Four-channel always shifts; eight-channel waits for strobe
                    if (!eight_channel_mode || !lsb_first_strobe_n) begin
                        next_st.out_shift = {1'b0, st.out_shift[8:1]};
                        next_st.data_out = st.out_shift[1];
                    end
                end
                default: begin
                    next_st.state = ST_START;
                end
            endcase
        end
        // Switch enables follow the word only while converting
        if (next_st.state == ST_CONV && !select_line_n) begin
            next_st.pos_sel = dec_pos;
            next_st.neg_sel = dec_neg;
            next_st.neg_common = dec_common;
        end else begin
            next_st.pos_sel = SEL_RESET;
            next_st.neg_sel = SEL_RESET;
            next_st.neg_common = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
            st.state <= ST_START;
            st.data_out_en_n <= 1'b1;
            st.out_shift <= SHIFT_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign serial_out_line = st.data_out;
    assign serial_out_en_n = st.data_out_en_n;
    assign conversion_busy_flag = st.busy;
    assign trial_code = st.trial;
    assign pos_channel_sel = st.pos_sel;
    assign neg_channel_sel = st.neg_sel;
    assign shared_negative_input = st.neg_common;

    // ======================================================================
    // Checks
    logic [3:0] busy_edges;

    // Converter edges seen while busy
    always_ff @(posedge clk) begin
        if (rst || !st.busy) begin
            busy_edges <= 4'h0;
        end else if (conv_edge && !select_line_n) begin
            busy_edges <= busy_edges + 4'h1;
        end
    end

    a_busy_eight_edges: assert property (@(posedge clk) disable iff (rst)
        $fell(conversion_busy_flag) && !$past(select_line_n) |-> busy_edges == 4'h8)
        else $error("busy did not last eight converter clocks");

    a_settle_low: assert property (@(posedge clk) disable iff (rst)
        $rose(conversion_busy_flag) |-> !serial_out_en_n && !serial_out_line)
        else $error("no leading low at conversion start");

    a_trial_msb: assert property (@(posedge clk) disable iff (rst)
        $rose(conversion_busy_flag) |-> trial_code == 8'h80 && $past(st.state) == ST_HOLD)
        else $error("conversion did not start at the most significant trial");

    a_deselect_clears: assert property (@(posedge clk) disable iff (rst)
        select_line_n |=> serial_out_en_n && !conversion_busy_flag && st.state == ST_START)
        else $error("deselect did not clear the block");

    a_addr_out_idle: assert property (@(posedge clk) disable iff (rst)
        st.state == ST_ADDR || st.state == ST_START |-> serial_out_en_n)
        else $error("output driven while input examined");

    a_msb_on_line: assert property (@(posedge clk) disable iff (rst)
        conv_edge && st.state == ST_CONV && !select_line_n
        |=> serial_out_line == $past(compare_high && !pos_below_neg))
        else $error("resolved bit not presented at once");

    a_below_zero: assert property (@(posedge clk) disable iff (rst)
        conv_edge && st.state == ST_CONV && !select_line_n && pos_below_neg
        |=> !serial_out_line && !st.approximation_register[$past(st.bit_cnt)])
        else $error("bit set with positive input below negative");

    a_lsb_hold: assert property (@(posedge clk) disable iff (rst)
        eight_channel_mode && st.state == ST_LSB && lsb_first_strobe_n && !select_line_n
        |=> $stable(serial_out_line))
        else $error("output moved while strobe high");

    a_four_sel_low: assert property (@(posedge clk) disable iff (rst)
        !eight_channel_mode && st.state == ST_CONV |-> st.select_bits[0])
        else $error("lower select bit not held high");

    a_hold_ignores_in: assert property (@(posedge clk) disable iff (rst)
        st.state == ST_CONV && !select_line_n |=> $stable(st.select_bits))
        else $error("assignment changed during conversion");

    a_push_room: assert property (@(posedge clk) disable iff (rst)
        st.push |-> fifo_in_ready)
        else $error("result pushed into a full buffer");

    a_busy_selects_one: assert property (@(posedge clk) disable iff (rst)
        $onehot0(pos_channel_sel) && (conversion_busy_flag == (|pos_channel_sel)))
        else $error("channel enable does not follow conversion");

    a_pair_adjacent: assert property (@(posedge clk) disable iff (rst)
        |neg_channel_sel |-> neg_channel_sel == (((pos_channel_sel & 8'h55) << 1)
                                                | ((pos_channel_sel & 8'haa) >> 1)))
        else $error("negative input is not the pair partner");

    a_start_bit_taken: assert property (@(posedge clk) disable iff (rst)
        conv_edge && !select_line_n && st.state == ST_START
        |=> (st.state == ST_ADDR) == $past(serial_in_line))
        else $error("start bit not recognised");

    a_common_only_eight: assert property (@(posedge clk) disable iff (rst)
        shared_negative_input |-> eight_channel_mode && neg_channel_sel == 8'h00)
        else $error("shared negative input used outside eight-channel single mode");

endmodule
`default_nettype wire

// file: adc_controller_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Controlling processor and analog front end facing the converter logic
module adc_controller_model (
    input wire logic clk,
    input wire logic [serial_adc_pkg::RESULT_BITS-1:0] trial_code,
    output logic select_line_n,
    output logic conv_clock,
    output logic serial_in_line,
    output logic lsb_first_strobe_n,
    output logic compare_high,
    output logic pos_below_neg
);
    import serial_adc_pkg::*;

    // Half period of the link clock in system cycles; larger is slower
    int half = 3;
    logic [7:0] level = 8'h00;
    logic below = 1'b0;

    // Idle link: deselected, link clock parked low
    initial begin
        select_line_n = 1'b1;
        conv_clock = 1'b0;
        serial_in_line = 1'b0;
        lsb_first_strobe_n = 1'b1;
    end

    // Input sits half a step above its code, so no trial ever ties
    assign compare_high = {level, 1'b1} > {trial_code, 1'b0};
    assign pos_below_neg = below;

    // Select change with the link clock stopped
    task automatic set_select(input logic sel_n);
        @(posedge clk);
        select_line_n <= sel_n;
        conv_clock <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    // One link clock: data set while low, outputs settle while high
    task automatic conv_cycle(input logic data_bit, input logic strobe_n);
        @(posedge clk);
        conv_clock <= 1'b0;
        serial_in_line <= data_bit;
        lsb_first_strobe_n <= strobe_n;
        repeat (half) @(posedge clk);
        conv_clock <= 1'b1;
        repeat (half) @(posedge clk);
        #1;
    endtask
endmodule
`default_nettype wire

// file: serial_mux_adc_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Self-checking bench for the serial converter control
module serial_mux_adc_control_tb;
    import serial_adc_pkg::*;
    localparam int LIMIT = 20000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic eight_channel_mode = 1'b1;
    logic result_ready = 1'b0;
    logic select_line_n, conv_clock, serial_in_line, lsb_first_strobe_n;
    logic compare_high, pos_below_neg, serial_out_line, serial_out_en_n;
    logic conversion_busy_flag, shared_negative_input, result_valid;
    logic [RESULT_BITS-1:0] trial_code, result_data;
    logic [CHANNELS-1:0] pos_channel_sel, neg_channel_sel;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    logic [7:0] expect_q[$];

    always #5 clk = ~clk;

    serial_mux_adc_control DUT (
        .clk, .rst, .eight_channel_mode, .select_line_n, .conv_clock, .serial_in_line,
        .lsb_first_strobe_n, .serial_out_line, .serial_out_en_n, .conversion_busy_flag,
        .compare_high, .pos_below_neg, .trial_code, .pos_channel_sel, .neg_channel_sel,
        .shared_negative_input, .result_valid, .result_data, .result_ready
    );

    adc_controller_model ctl (
        .clk, .trial_code, .select_line_n, .conv_clock, .serial_in_line,
        .lsb_first_strobe_n, .compare_high, .pos_below_neg
    );

    // ==========================================================================
    // Comparison and closing
    task automatic check(input string name, input logic [8:0] exp, input logic [8:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic give_verdict();
        if (fail_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fail_count++;
            give_verdict();
        end
    end

    // ==========================================================================
    // Link sequences
    task automatic deselect_check();
        ctl.set_select(1'b1);
        check("en_n_clear", 9'h1, serial_out_en_n);
        check("busy_clear", 9'h0, conversion_busy_flag);
        check("trial_clear", 9'h0, trial_code);
        check("sel_clear", 9'h0, pos_channel_sel);
    endtask

    // One selection; stop < 0 expects a held-off start, stop < 8 aborts early
    task automatic run_conv(input logic [3:0] word, input logic [7:0] lvl, input logic below,
        input int lead, input int stop);
        logic [7:0] r;
        int p;
        r = below ? 8'h00 : lvl;
        ctl.level = lvl;
        ctl.below = below;
        ctl.set_select(1'b0);
        repeat (lead) begin
            ctl.conv_cycle(1'b0, 1'b1);
            check("en_n_addr", 9'h1, serial_out_en_n);
        end
        ctl.conv_cycle(1'b1, 1'b1);
        ctl.conv_cycle(word[3], 1'b1);
        ctl.conv_cycle(word[2], 1'b1);
        ctl.conv_cycle(word[1], 1'b1);
        if (eight_channel_mode) begin
            ctl.conv_cycle(word[0], 1'b1);
        end
        check("busy_addr", 9'h0, conversion_busy_flag);
        ctl.conv_cycle(1'b1, 1'b1);
        if (stop < 0) begin
            check("busy_full", 9'h0, conversion_busy_flag);
            check("en_n_full", 9'h1, serial_out_en_n);
            deselect_check();
            return;
        end
        p = 2 * (eight_channel_mode ? int'(word[1:0]) : int'(word[1])) + int'(word[2]);
        check("busy_start", 9'h1, conversion_busy_flag);
        check("lead_low", 9'h0, {serial_out_en_n, serial_out_line});
        check("trial", 9'h080, trial_code);
        check("pos_sel", 9'h1 << p, pos_channel_sel);
        check("neg_sel", word[3] ? 9'h0 : 9'h1 << (p ^ 1), neg_channel_sel);
        check("common", word[3] & eight_channel_mode, shared_negative_input);
        for (int i = 7; i >= 0; i--) begin
            if (7 - i == stop) begin
                deselect_check();
                return;
            end
            ctl.conv_cycle(i[0], 1'b1);
            check("msb_bit", r[i], serial_out_line);
            check("busy_run", i > 0, conversion_busy_flag);
        end
        expect_q.push_back(r);
        if (eight_channel_mode) begin
            repeat (2) begin
                ctl.conv_cycle(1'b0, 1'b1);
                check("lsb_hold", r[0], serial_out_line);
            end
        end
        for (int i = 1; i < 9; i++) begin
            ctl.conv_cycle(1'b0, ~eight_channel_mode);
            check("lsb_bit", i < 8 ? r[i] : 1'b0, serial_out_line);
        end
        deselect_check();
    endtask

    // ==========================================================================
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check("en_n_reset", 9'h1, serial_out_en_n);
        check("busy_reset", 9'h0, conversion_busy_flag);
        check("valid_reset", 9'h0, result_valid);
        // Eight channels, every word, results left in the buffer
        for (int w = 0; w < 16; w++) begin
            run_conv(w[3:0], 8'(w * 17), 1'b0, w % 3, 8);
        end
        check("fifo_full", 9'h1, result_valid);
        run_conv(4'h8, 8'h55, 1'b0, 0, -1);
        // Drain the buffer in order
        while (expect_q.size() > 0) begin
            @(posedge clk);
            #1;
            check("fifo_valid", 9'h1, result_valid);
            check("fifo_data", expect_q.pop_front(), result_data);
            // Ready high for exactly one edge, so one word leaves per pass
            @(posedge clk);
            result_ready <= 1'b1;
            @(posedge clk);
            result_ready <= 1'b0;
        end
        repeat (3) @(posedge clk);
        result_ready <= 1'b0;
        #1;
        check("fifo_empty", 9'h0, result_valid);
        @(posedge clk);
        result_ready <= 1'b1;
        // Abort mid-conversion, then a fresh selection with input below negative
        run_conv(4'hc, 8'ha5, 1'b0, 1, 3);
        run_conv(4'h6, 8'hc3, 1'b1, 0, 8);
        // Four channels with a slower link clock
        @(posedge clk);
        eight_channel_mode <= 1'b0;
        ctl.half = 6;
        for (int w = 0; w < 8; w++) begin
            run_conv({w[2:0], 1'b0}, 8'(w * 36 + 1), 1'b0, w % 2, 8);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
